/* dual_timer_counter.sv */
// Purpose: two timer/counters with mode and run/flag control registers
// Assumes: sfr accesses and pins are synchronous to clk
// Notes: timer 1 has no gate or count source; split mode borrows its controls
`timescale 1ns/1ps
`default_nettype none
module dual_timer_counter (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clkEn,
   input wire timer_pkg::sfr_req_s sfrReq,
   input wire logic externalGateInput,
   input wire logic externalCountPin,
   output logic [7:0] sfrRdData,
   output logic [7:0] timerRunFlagControl,
   output logic [7:0] timerModeConfig
);
   import timer_pkg::*;
   localparam int PHASE_W = $clog2(MACHINE_CLOCKS);

   ////////////////////////////////////////////////////////////////////////
   logic [7:0] ctrl_q, ctrl_d, mode_q, rdData_q, rdData_d;
   logic [PHASE_W-1:0] phase_q;
   logic pinPrev_q;
   count_pair_s cnt0, cnt1;
   logic t0LowOvf, t0HighOvf, t1LowOvf, t1HighOvf;

   wire machineTick = (phase_q == PHASE_W'(MACHINE_CLOCKS - 1));
   wire wrCtrl = sfrReq.wrEn && sfrReq.addr == CTRL_ADDR;
   wire wrMode = sfrReq.wrEn && sfrReq.addr == MODE_ADDR;
   wire wrT0Low = sfrReq.wrEn && sfrReq.addr == T0_LOW_ADDR;
   wire wrT0High = sfrReq.wrEn && sfrReq.addr == T0_HIGH_ADDR;
   wire wrT1Low = sfrReq.wrEn && sfrReq.addr == T1_LOW_ADDR;
   wire wrT1High = sfrReq.wrEn && sfrReq.addr == T1_HIGH_ADDR;
   timer_mode_e mode0, mode1;
   assign mode0 = timer_mode_e'(mode_q[MODE_T0_LSB +: 2]);
   assign mode1 = timer_mode_e'(mode_q[MODE_T1_LSB +: 2]);
   wire run0 = ctrl_q[CTRL_RUN0_BIT];
   wire run1 = ctrl_q[CTRL_RUN1_BIT];
   wire gateOn = mode_q[MODE_GATE_BIT];
   wire srcPin = mode_q[MODE_SRC_BIT];

   ////////////////////////////////////////////////////////////////////////
   // pin sampled once per machine cycle so the edge is high then low samples
   wire pinFall = machineTick && pinPrev_q && !externalCountPin;
   wire t0Enable = run0 && (!gateOn || externalGateInput);
   wire t0Tick = t0Enable && (srcPin ? pinFall : machineTick);
   wire t1Tick = run1 && machineTick && mode1 != MODE_SPLIT;
   wire t0HighTick = run1 && machineTick;

   timer_count_unit u_timer0 (
      .clk(clk),
      .sys_rst(sys_rst),
      .clkEn(clkEn),
      .mode(mode0),
      .lowTick(t0Tick),
      .highTick(t0HighTick),
      .wrLow(wrT0Low),
      .wrHigh(wrT0High),
      .wrData(sfrReq.wrData),
      .count(cnt0),
      .lowOvf(t0LowOvf),
      .highOvf(t0HighOvf)
   );

   timer_count_unit u_timer1 (
      .clk(clk),
      .sys_rst(sys_rst),
      .clkEn(clkEn),
      .mode(mode1),
      .lowTick(t1Tick),
      .highTick(1'b0),
      .wrLow(wrT1Low),
      .wrHigh(wrT1High),
      .wrData(sfrReq.wrData),
      .count(cnt1),
      .lowOvf(t1LowOvf),
      .highOvf(t1HighOvf)
   );

   ////////////////////////////////////////////////////////////////////////
   // timer 1 flag is owned by timer 0 high byte while timer 0 is split
   wire ovf1Set = (mode0 == MODE_SPLIT) ? t0HighOvf : t1LowOvf;
   wire ovf0Set = t0LowOvf;

   // set wins over a software clear in the same cycle; the run bits only
   // store, so starting a timer leaves its counts alone
   always_comb begin
      ctrl_d = ctrl_q;
      if (wrCtrl) ctrl_d = sfrReq.wrData & 8'hF3;
      if (ovf1Set) ctrl_d[CTRL_OVF1_BIT] = 1'b1;
      if (ovf0Set) ctrl_d[CTRL_OVF0_BIT] = 1'b1;
   end

   // upper low-byte bits in mode 00 read back raw; software must mask
   always_comb begin
      unique case (sfrReq.addr)
         CTRL_ADDR: rdData_d = ctrl_d;
         MODE_ADDR: rdData_d = mode_q;
         T0_LOW_ADDR: rdData_d = cnt0.low;
         T1_LOW_ADDR: rdData_d = cnt1.low;
         T0_HIGH_ADDR: rdData_d = cnt0.high;
         T1_HIGH_ADDR: rdData_d = cnt1.high;
         default: rdData_d = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_q <= CTRL_RESET;
         mode_q <= MODE_RESET;
         phase_q <= '0;
         pinPrev_q <= 1'b0;
         rdData_q <= 8'h00;
      end else if (clkEn) begin
         ctrl_q <= ctrl_d;
         if (wrMode) mode_q <= sfrReq.wrData;
         phase_q <= machineTick ? '0 : phase_q + PHASE_W'(1);
         if (machineTick) pinPrev_q <= externalCountPin;
         if (sfrReq.rdEn) rdData_q <= rdData_d;
      end
   end

   assign sfrRdData = rdData_q;
   assign timerRunFlagControl = ctrl_q;
   assign timerModeConfig = mode_q;

   ////////////////////////////////////////////////////////////////////////
   property p_t0_gate;
      @(posedge clk) disable iff (sys_rst)
      clkEn && gateOn && !externalGateInput && !wrT0Low
         |=> cnt0.low == $past(cnt0.low);
   endproperty
   a_t0_gate: assert property (p_t0_gate) else $error("timer 0 counted while gated");

   property p_ovf0_set;
      @(posedge clk) disable iff (sys_rst)
      clkEn && ovf0Set |=> ctrl_q[CTRL_OVF0_BIT];
   endproperty
   a_ovf0_set: assert property (p_ovf0_set) else $error("overflow 0 not set");

   property p_run_keeps_count;
      @(posedge clk) disable iff (sys_rst)
      clkEn && wrCtrl && !run0 && sfrReq.wrData[CTRL_RUN0_BIT] && !t0Tick
         && !(sfrReq.addr == T0_LOW_ADDR) |=> cnt0 == $past(cnt0);
   endproperty
   a_run_keeps_count: assert property (p_run_keeps_count) else $error("start cleared count");

   property p_ctrl_reserved;
      @(posedge clk) disable iff (sys_rst)
      ctrl_q[3:2] == 2'h0;
   endproperty
   a_ctrl_reserved: assert property (p_ctrl_reserved) else $error("reserved control bits set");

   property p_t1_halt;
      @(posedge clk) disable iff (sys_rst)
      clkEn && mode1 == MODE_SPLIT && !(sfrReq.wrEn) ##1 mode1 == MODE_SPLIT |-> cnt1 == $past(cnt1);
   endproperty
   a_t1_halt: assert property (p_t1_halt) else $error("timer 1 counted while halted");

   property p_reload;
      @(posedge clk) disable iff (sys_rst)
      clkEn && mode0 == MODE_RELOAD && t0Tick && cnt0.low == 8'hFF && !sfrReq.wrEn
         |=> cnt0.low == $past(cnt0.high) && ctrl_q[CTRL_OVF0_BIT];
   endproperty
   a_reload: assert property (p_reload) else $error("reload missed");

   property p_t1_rate;
      @(posedge clk) disable iff (sys_rst)
      clkEn && !(run1 && machineTick) && !wrT1Low && !wrT1High |=> cnt1 == $past(cnt1);
   endproperty
   a_t1_rate: assert property (p_t1_rate) else $error("timer 1 moved off a running machine cycle");

   property p_pin_edge;
      @(posedge clk) disable iff (sys_rst)
      clkEn && srcPin && !pinFall && !wrT0Low |=> cnt0.low == $past(cnt0.low);
   endproperty
   a_pin_edge: assert property (p_pin_edge) else $error("pin counter moved without a falling edge");

   property p_ovf1_set;
      @(posedge clk) disable iff (sys_rst)
      clkEn && ovf1Set |=> ctrl_q[CTRL_OVF1_BIT];
   endproperty
   a_ovf1_set: assert property (p_ovf1_set) else $error("overflow 1 not set");

   property p_mode_hold;
      @(posedge clk) disable iff (sys_rst)
      clkEn && !wrMode |=> mode_q == $past(mode_q);
   endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("mode register changed without a write");

   property p_split_high;
      @(posedge clk) disable iff (sys_rst)
      clkEn && mode0 == MODE_SPLIT && run1 && machineTick && !wrT0High |=> cnt0.high == $past(cnt0.high) + 8'h01;
   endproperty
   a_split_high: assert property (p_split_high) else $error("split high byte missed a machine cycle");

   property p_prescale_top;
      @(posedge clk) disable iff (sys_rst)
      clkEn && mode0 == MODE_13BIT && !wrT0Low |=> cnt0.low[7:5] == $past(cnt0.low[7:5]);
   endproperty
   a_prescale_top: assert property (p_prescale_top) else $error("upper low bits counted in 13-bit mode");

   property p_sixteen_carry;
      @(posedge clk) disable iff (sys_rst)
      clkEn && mode1 == MODE_16BIT && t1Tick && cnt1.low == 8'hFF && !wrT1Low && !wrT1High
         |=> cnt1.low == 8'h00 && cnt1.high == $past(cnt1.high) + 8'h01;
   endproperty
   a_sixteen_carry: assert property (p_sixteen_carry) else $error("16-bit carry missed");
endmodule
`default_nettype wire

/* timer_pkg.sv */
// Purpose: shared constants and carriers for the dual timer/counter
// Assumes: byte-wide special function register accesses from the cpu core
// Notes: one machine cycle is a fixed number of cpu clocks
package timer_pkg;
   localparam logic [7:0] CTRL_ADDR = 8'h88;
   localparam logic [7:0] MODE_ADDR = 8'h89;
   localparam logic [7:0] T0_LOW_ADDR = 8'h8A;
   localparam logic [7:0] T1_LOW_ADDR = 8'h8B;
   localparam logic [7:0] T0_HIGH_ADDR = 8'h8C;
   localparam logic [7:0] T1_HIGH_ADDR = 8'h8D;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam int CTRL_OVF1_BIT = 7;
   localparam int CTRL_RUN1_BIT = 6;
   localparam int CTRL_OVF0_BIT = 5;
   localparam int CTRL_RUN0_BIT = 4;
   localparam int MODE_T1_LSB = 4;
   localparam int MODE_GATE_BIT = 3;
   localparam int MODE_SRC_BIT = 2;
   localparam int MODE_T0_LSB = 0;
   localparam int MACHINE_CLOCKS = 6;
   localparam logic [4:0] PRESCALE_MAX = 5'h1F;

   typedef enum logic [1:0] {
      MODE_13BIT = 2'h0,
      MODE_16BIT = 2'h1,
      MODE_RELOAD = 2'h2,
      MODE_SPLIT = 2'h3
   } timer_mode_e;

   typedef struct packed {
      logic wrEn;
      logic rdEn;
      logic [7:0] addr;
      logic [7:0] wrData;
   } sfr_req_s;

   typedef struct packed {
      logic [7:0] high;
      logic [7:0] low;
   } count_pair_s;
endpackage

/* timer_count_unit.sv */
// Purpose: one timer's count register pair with its four modes
// Assumes: tick enables already gated by run and gate logic
// Notes: overflow pulses are one clock wide
`timescale 1ns/1ps
`default_nettype none
module timer_count_unit (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clkEn,
   input wire timer_pkg::timer_mode_e mode,
   input wire logic lowTick,
   input wire logic highTick,
   input wire logic wrLow,
   input wire logic wrHigh,
   input wire logic [7:0] wrData,
   output timer_pkg::count_pair_s count,
   output logic lowOvf,
   output logic highOvf
);
   import timer_pkg::*;
   count_pair_s count_q, count_d;
   wire lowAllOnes = (count_q.low == 8'hFF);
   wire highAllOnes = (count_q.high == 8'hFF);
   wire preAllOnes = (count_q.low[4:0] == PRESCALE_MAX);

   always_comb begin
      count_d = count_q;
      lowOvf = 1'b0;
      highOvf = 1'b0;
      unique case (mode)
         MODE_13BIT: if (lowTick) begin
            count_d.low = {count_q.low[7:5], count_q.low[4:0] + 5'h01};
            if (preAllOnes) begin
               count_d.high = count_q.high + 8'h01;
               lowOvf = highAllOnes;
            end
         end
         MODE_16BIT: if (lowTick) begin
            count_d.low = count_q.low + 8'h01;
            if (lowAllOnes) begin
               count_d.high = count_q.high + 8'h01;
               lowOvf = highAllOnes;
            end
         end
         MODE_RELOAD: if (lowTick) begin
            count_d.low = lowAllOnes ? count_q.high : count_q.low + 8'h01;
            lowOvf = lowAllOnes;
         end
         MODE_SPLIT: begin
            if (lowTick) begin
               count_d.low = count_q.low + 8'h01;
               lowOvf = lowAllOnes;
            end
            if (highTick) begin
               count_d.high = count_q.high + 8'h01;
               highOvf = highAllOnes;
            end
         end
      endcase
      // cpu writes win over counting in the same cycle
      if (wrLow) count_d.low = wrData;
      if (wrHigh) count_d.high = wrData;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) count_q <= '{high: COUNT_RESET, low: COUNT_RESET};
      else if (clkEn) count_q <= count_d;
   end
   assign count = count_q;
endmodule
`default_nettype wire

/* cpu_sfr_model.sv */
// Purpose: cpu core stand-in issuing byte register accesses
// Assumes: strobes launched at falling clk, taken at the next rising edge
// Notes: one request per call; nothing else is driven between calls
`timescale 1ns/1ps
`default_nettype none
module cpu_sfr_model (
   input wire logic clk,
   output timer_pkg::sfr_req_s sfrReq,
   input wire logic [7:0] sfrRdData
);
   import timer_pkg::*;
   initial sfrReq = '0;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      sfrReq <= '{1'b1, 1'b0, a, d};
      @(negedge clk);
      sfrReq <= '0;
   endtask
   // data is registered at the rising edge that takes rdEn
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      sfrReq <= '{1'b0, 1'b1, a, 8'h00};
      @(negedge clk);
      d = sfrRdData;
      sfrReq <= '0;
   endtask
endmodule
`default_nettype wire

/* tb_dual_timer_counter.sv */
// Purpose: self-checking bench for the dual timer/counter
// Assumes: machine cycle of 6 clk, clkEn high except for 30 clk in the split test
// Notes: waits leave slack for machine-cycle phase
`timescale 1ns/1ps
`default_nettype none
module tb_dual_timer_counter;
   import timer_pkg::*;
   logic clk = 1'b0;
   logic sysRst = 1'b1;
   logic gateIn = 1'b0;
   logic cntPin = 1'b1;
   logic clkEn = 1'b1;
   sfr_req_s sfrReq;
   logic [7:0] rdData, ctrlQ, modeQ, v, w;
   int fail_count = 0;
   int n_compared = 0;
   dual_timer_counter dut (.clk(clk), .sys_rst(sysRst), .clkEn(clkEn), .sfrReq(sfrReq),
      .externalGateInput(gateIn), .externalCountPin(cntPin), .sfrRdData(rdData),
      .timerRunFlagControl(ctrlQ), .timerModeConfig(modeQ));
   cpu_sfr_model cpu (.clk(clk), .sfrReq(sfrReq), .sfrRdData(rdData));
   initial begin
      forever #50 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      cpu.rd(a, v);
      chk(v & m, e, "register read");
   endtask
   task automatic setup(input logic [7:0] md, input logic [7:0] lo, input logic [7:0] hi, input logic t1);
      cpu.wr(CTRL_ADDR, 8'h00);
      cpu.wr(MODE_ADDR, md);
      cpu.wr(t1 ? T1_LOW_ADDR : T0_LOW_ADDR, lo);
      cpu.wr(t1 ? T1_HIGH_ADDR : T0_HIGH_ADDR, hi);
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic t_reset();
      chk(ctrlQ, CTRL_RESET, "control reset");
      rc(8'h80, 8'hFF, 8'h00);
      cpu.wr(MODE_ADDR, 8'h35);
      rc(MODE_ADDR, 8'hFF, 8'h35);
      chk(modeQ, 8'h35, "mode register output");
      $display("test reset done");
   endtask
   task automatic t_sixteen();
      setup(8'h10, 8'hFE, 8'hFF, 1'b1);
      cpu.wr(CTRL_ADDR, 8'h40);
      rc(T1_LOW_ADDR, 8'hFE, 8'hFE);
      repeat (20) @(negedge clk);
      chk(ctrlQ, 8'hC0, "timer 1 wrap flag");
      rc(T1_HIGH_ADDR, 8'hFF, 8'h00);
      rc(T1_LOW_ADDR, 8'hF0, 8'h00);
      $display("test sixteen done");
   endtask
   task automatic t_reload();
      setup(8'h02, 8'hFE, 8'hF0, 1'b0);
      cpu.wr(CTRL_ADDR, 8'h10);
      repeat (20) @(negedge clk);
      chk(ctrlQ, 8'h30, "reload flag");
      rc(T0_HIGH_ADDR, 8'hFF, 8'hF0);
      rc(T0_LOW_ADDR, 8'hFC, 8'hF0);
      $display("test reload done");
   endtask
   task automatic t_gate13();
      setup(8'h08, 8'h00, 8'h00, 1'b0);
      cpu.wr(CTRL_ADDR, 8'h10);
      repeat (30) @(negedge clk);
      rc(T0_LOW_ADDR, 8'h1F, 8'h00);
      gateIn = 1'b1;
      repeat (30) @(negedge clk);
      cpu.rd(T0_LOW_ADDR, v);
      chk({7'h00, |(v & 8'h1F)}, 8'h01, "gated count runs");
      gateIn = 1'b0;
      setup(8'h00, 8'h1F, 8'hFF, 1'b0);
      cpu.wr(CTRL_ADDR, 8'h10);
      repeat (14) @(negedge clk);
      chk(ctrlQ, 8'h30, "13-bit wrap flag");
      $display("test gate13 done");
   endtask
   task automatic t_pin();
      setup(8'h05, 8'h00, 8'h00, 1'b0);
      cpu.wr(CTRL_ADDR, 8'h10);
      repeat (5) begin
         repeat (12) @(negedge clk);
         cntPin = 1'b0;
         repeat (12) @(negedge clk);
         cntPin = 1'b1;
      end
      repeat (6) @(negedge clk);
      rc(T0_LOW_ADDR, 8'hFF, 8'h05);
      $display("test pin done");
   endtask
   task automatic t_split();
      setup(8'h03, 8'h00, 8'h00, 1'b0);
      cpu.wr(CTRL_ADDR, 8'h40);
      repeat (30) @(negedge clk);
      rc(T0_LOW_ADDR, 8'hFF, 8'h00);
      cpu.rd(T0_HIGH_ADDR, v);
      chk({7'h00, v > 8'h02}, 8'h01, "split high byte");
      clkEn = 1'b0;
      repeat (30) @(negedge clk);
      clkEn = 1'b1;
      cpu.rd(T0_HIGH_ADDR, w);
      chk({7'h00, (w - v) < 8'h02}, 8'h01, "clock enable freezes count");
      cpu.wr(MODE_ADDR, 8'h33);
      cpu.rd(T1_LOW_ADDR, v);
      repeat (30) @(negedge clk);
      rc(T1_LOW_ADDR, 8'hFF, v);
      $display("test split done");
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk);
      fail_count++;
      print_verdict();
   end
   initial begin
      repeat (3) @(negedge clk);
      sysRst = 1'b0;
      t_reset();
      t_sixteen();
      t_reload();
      t_gate13();
      t_pin();
      t_split();
      print_verdict();
   end
endmodule
`default_nettype wire
